// File: inc/diag_adc_pkg.sv
/*
  Shared constants and types for the diagnostic converter request queue:
  command slot addresses, select codes, reset values and frame layouts.
  Assumes the SPI slave delivers decoded command frames on sys_clk.
*/
package diag_adc_pkg;

  localparam logic [7:0] ADDR_CHANNEL_A = 8'h3A;
  localparam logic [7:0] ADDR_CHANNEL_B = 8'h3B;
  localparam logic [7:0] ADDR_CHANNEL_C = 8'h3C;
  localparam logic [7:0] ADDR_CHANNEL_D = 8'h3D;

  localparam int NUM_CHANNELS = 4;
  localparam int QUEUE_DEPTH = 4;
  localparam int CODE_W = 7;
  localparam int RESULT_W = 10;
  localparam int CMD_W = 16;
  localparam int CODE_LSB = 0;

  localparam logic [1:0] CHAN_A = 2'h0;
  localparam logic [1:0] CHAN_B = 2'h1;

  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;

  localparam logic [CODE_W-1:0] CODE_GROUND = 7'h01;
  localparam logic [CODE_W-1:0] CODE_FULLSCALE = 7'h02;
  localparam logic [CODE_W-1:0] CODE_DCS_VOLT = 7'h03;
  localparam logic [CODE_W-1:0] CODE_DCS_CURR = 7'h04;
  localparam logic [CODE_W-1:0] CODE_DCS_RES = 7'h05;
  localparam logic [CODE_W-1:0] CODE_SQUIB = 7'h06;
  localparam logic [CODE_W-1:0] CODE_BANDGAP = 7'h07;
  localparam logic [CODE_W-1:0] CODE_BG_MON = 7'h08;
  localparam logic [CODE_W-1:0] CODE_TEMP = 7'h0A;
  localparam logic [CODE_W-1:0] CODE_DCS_CH_FIRST = 7'h0B;
  localparam logic [CODE_W-1:0] CODE_DCS_CH_LAST = 7'h13;
  localparam logic [CODE_W-1:0] CODE_ESR_B = 7'h14;
  localparam logic [CODE_W-1:0] CODE_ESR_A = 7'h15;
  localparam logic [CODE_W-1:0] CODE_ESR_C = 7'h16;
  localparam logic [CODE_W-1:0] CODE_NODE_FIRST = 7'h20;

  typedef enum logic [3:0] {
    NODE_UNUSED, NODE_GROUND, NODE_FULLSCALE, NODE_DCS_VOLT, NODE_DCS_CURR,
    NODE_DCS_RES, NODE_SQUIB, NODE_BANDGAP, NODE_BG_MON, NODE_TEMP,
    NODE_DCS_CHANNEL, NODE_ESR, NODE_PIN
  } node_class_type;

  typedef struct packed {
    node_class_type node;
    logic [5:0] index;
  } node_sel_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [CMD_W-1:0] wdata;
  } spi_cmd_type;

  typedef struct packed {
    logic flag;
    logic [1:0] zero;
    logic [CODE_W-1:0] code;
    logic [RESULT_W-1:0] result;
  } diag_frame_type;

endpackage

// File: rtl/diag_select_decode.sv
/*
  Maps a 7-bit measurement select code onto a multiplexer node class and index.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
module diag_select_decode
  import diag_adc_pkg::*;
(
  input wire logic [CODE_W-1:0] code,
  output node_sel_type sel
);

  always_comb begin
    sel.index = 6'h00;
    sel.node = NODE_UNUSED; // R21
    if (code >= CODE_NODE_FIRST) begin
      sel.node = NODE_PIN; // R20
      sel.index = 6'(code - CODE_NODE_FIRST);
    end else if (code >= CODE_DCS_CH_FIRST && code <= CODE_DCS_CH_LAST) begin
      sel.node = NODE_DCS_CHANNEL; // R16
      sel.index = 6'(code - CODE_DCS_CH_FIRST);
    end else if (code >= CODE_ESR_B && code <= CODE_ESR_C) begin
      sel.node = NODE_ESR; // R17
      sel.index = 6'(code - CODE_ESR_B);
    end else begin
      unique case (code)
        CODE_GROUND: sel.node = NODE_GROUND; // R13
        CODE_FULLSCALE: sel.node = NODE_FULLSCALE; // R13
        CODE_DCS_VOLT: sel.node = NODE_DCS_VOLT; // R14
        CODE_DCS_CURR: sel.node = NODE_DCS_CURR; // R14
        CODE_DCS_RES: sel.node = NODE_DCS_RES; // R14
        CODE_SQUIB: sel.node = NODE_SQUIB; // R15
        CODE_BANDGAP: sel.node = NODE_BANDGAP; // R13
        CODE_BG_MON: sel.node = NODE_BG_MON; // R13
        CODE_TEMP: sel.node = NODE_TEMP; // R15
        default: sel.node = NODE_UNUSED; // R21
      endcase
    end
  end

endmodule // diag_select_decode
`default_nettype wire

// File: rtl/diag_req_fifo.sv
/*
  Small first-in first-out queue of channel numbers held in flip-flops.
  Push and pop may happen in the same cycle; a full queue takes a push only
  together with a pop, so a slot freed by the pop is reused at once.
*/
`timescale 1ns/1ns
`default_nettype none
module diag_req_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
      $error("fifo depth must be a power of two and at least two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic take_push;
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;

  assign head = mem_q[rd_q[PW-1:0]];
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  // refusing a push beside a pop would lose a request that is marked pending
  assign take_push = push && (!full || pop);

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    mem_d = mem_q;
    if (take_push) begin
      wr_d = wr_q + 1'b1;
      mem_d[wr_q[PW-1:0]] = push_data;
    end
    if (pop && !empty)
      rd_d = rd_q + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end

endmodule // diag_req_fifo
`default_nettype wire

// File: rtl/diag_adc_request_queue.sv
/*
  Diagnostic converter request queue: four command slots, per-slot result
  storage and fresh flags, an in-order request queue and converter sequencing.
  Assumes the SPI slave hands over whole frames on sys_clk and the converter
  answers each start pulse with exactly one done pulse on sys_clk.
*/
//
// Contract
// R1: four channels at command addresses 3A to 3D
// R2: select code in bits 6:0, rest ignored
// R3: reply: flag, two zeros, echo code, result
// R4: result returns on the requesting channel
// R5: up to four conversions per batch
// R6: ready pairs are ORs of A/B, C/D flags
// R7: flag set at done, cleared on read
// R8: reading keeps the stored result
// R9: queued conversions run in arrival order
// R10: queue holds four requests
// R11: repeat request replaces pending one
// R12: host settles slow inputs before requesting
// R13: codes 01,02,07,08 map to references
// R14: codes 03 to 05 map to DC sensor
// R15: code 06 squib loop, 0A temperature
// R16: codes 0B to 13 map sensor channels
// R17: codes 14 to 16 select SERIES_RESISTANCE_CHECK voltages
// R18: resistance on A: current A, voltage B
// R19: SERIES_RESISTANCE_CHECK echo only when SERIES_RESISTANCE_CHECK results available
// R20: codes from 21 map to node voltages (the code maps from 20)
// R21: unused codes convert without fault
// R22: reset clears flags, queue and results
`timescale 1ns/1ns
`default_nettype none
module diag_adc_request_queue
  import diag_adc_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire spi_cmd_type cmd,
  output logic rsp_valid,
  output diag_frame_type rsp,
  output logic ready_pair_low,
  output logic ready_pair_high,
  input wire logic esr_results_available,
  output logic conv_start,
  output node_sel_type conv_sel,
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conv_result,
  input wire logic [RESULT_W-1:0] conv_result_aux,
  output logic conv_busy,
  output logic [3:0] pending_mask
);

  // one queue slot per channel, so a batch of four requests never overflows
  initial begin
    if (CHANNELS != 4 || DEPTH < CHANNELS)
      $error("block serves four channels with a queue of at least four"); // R5 R10
    if ($bits(diag_frame_type) != 20 || CODE_LSB + CODE_W > CMD_W)
      $error("reply frame must be 20 bits and the code must fit the command");
    if ($bits(node_sel_type) != 10)
      $error("converter select must be a 4-bit class and a 6-bit index");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01
  } conv_state_type;

  // per-channel storage
  logic [3:0] fresh_q, fresh_d;
  logic [3:0] pend_q, pend_d;
  logic [CODE_W-1:0] pend_code_q [4];
  logic [CODE_W-1:0] pend_code_d [4];
  logic [RESULT_W-1:0] result_q [4];
  logic [RESULT_W-1:0] result_d [4];
  logic [CODE_W-1:0] res_code_q [4];
  logic [CODE_W-1:0] res_code_d [4];

  // converter sequencing
  conv_state_type state_q, state_d;
  logic [1:0] active_chan_q, active_chan_d;
  logic [CODE_W-1:0] active_code_q, active_code_d;
  logic conv_start_q, conv_start_d;
  node_sel_type conv_sel_q, conv_sel_d;
  node_sel_type decoded_sel;

  // reply side
  logic rsp_valid_q, rsp_valid_d;
  diag_frame_type rsp_q, rsp_d;
  logic ready_low_q, ready_low_d;
  logic ready_high_q, ready_high_d;

  // command decode
  logic req_hit;
  logic [1:0] req_chan;
  logic [CODE_W-1:0] req_code;

  // queue handshake
  logic q_push, q_pop, q_empty;
  logic [1:0] q_head;
  logic start_now;
  logic done_now;
  logic split_res;

  function automatic logic is_esr_code(input logic [CODE_W-1:0] c);
    return (c >= CODE_ESR_B) && (c <= CODE_ESR_C);
  endfunction

  // the status word carries one ready bit per pair of slots
  function automatic logic pair_ready(input logic [3:0] flags, input logic upper);
    return upper ? (flags[2] | flags[3]) : (flags[0] | flags[1]);
  endfunction

  always_comb begin
    req_hit = 1'b0;
    req_chan = CHAN_A;
    if (cmd_valid) begin
      unique case (cmd.addr)
        ADDR_CHANNEL_A: begin // R1
          req_hit = 1'b1;
          req_chan = 2'h0;
        end
        ADDR_CHANNEL_B: begin // R1
          req_hit = 1'b1;
          req_chan = 2'h1;
        end
        ADDR_CHANNEL_C: begin // R1
          req_hit = 1'b1;
          req_chan = 2'h2;
        end
        ADDR_CHANNEL_D: begin // R1
          req_hit = 1'b1;
          req_chan = 2'h3;
        end
        default: req_hit = 1'b0;
      endcase
    end
  end

  // upper bits of the command word carry no meaning
  assign req_code = cmd.wdata[CODE_LSB +: CODE_W]; // R2

  diag_select_decode u_decode (
    .code(pend_code_q[q_head]),
    .sel(decoded_sel)
  );

  assign start_now = (state_q == ST_IDLE) && !q_empty;
  assign q_pop = start_now; // R9
  // a channel already waiting is rewritten in place and keeps its slot
  assign q_push = req_hit && !(pend_q[req_chan] && !(start_now && q_head == req_chan)); // R11
  assign done_now = (state_q == ST_CONVERT) && conv_done;
  assign split_res = (active_code_q == CODE_DCS_RES) && (active_chan_q == CHAN_A); // R18

  diag_req_fifo #(
    .WIDTH(2),
    .DEPTH(DEPTH)
  ) u_queue (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .push(q_push), // R10
    .push_data(req_chan),
    .pop(q_pop),
    .head(q_head),
    .empty(q_empty),
    .full()
  );

  always_comb begin
    state_d = state_q;
    active_chan_d = active_chan_q;
    active_code_d = active_code_q;
    conv_start_d = 1'b0;
    conv_sel_d = conv_sel_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_now) begin // R9
          state_d = ST_CONVERT;
          active_chan_d = q_head;
          active_code_d = pend_code_q[q_head];
          conv_sel_d = decoded_sel; // R21
          conv_start_d = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (conv_done)
          state_d = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    fresh_d = fresh_q;
    pend_d = pend_q;
    pend_code_d = pend_code_q;
    result_d = result_q;
    res_code_d = res_code_q;
    if (start_now)
      pend_d[q_head] = 1'b0;
    if (req_hit) begin
      pend_d[req_chan] = 1'b1; // R11
      pend_code_d[req_chan] = req_code;
      fresh_d[req_chan] = 1'b0; // R7
    end
    // the clear from the read goes first so a finishing conversion wins
    if (done_now) begin
      if (split_res) begin
        result_d[CHAN_A] = conv_result; // R18
        res_code_d[CHAN_A] = active_code_q;
        fresh_d[CHAN_A] = 1'b1;
        result_d[CHAN_B] = conv_result_aux; // R18
        res_code_d[CHAN_B] = active_code_q;
        fresh_d[CHAN_B] = 1'b1;
      end else begin
        result_d[active_chan_q] = conv_result; // R4 R8
        res_code_d[active_chan_q] = active_code_q;
        fresh_d[active_chan_q] = 1'b1; // R7
      end
    end
  end

  always_comb begin
    rsp_valid_d = req_hit;
    rsp_d = rsp_q;
    if (req_hit) begin
      rsp_d.flag = fresh_q[req_chan]; // R3
      rsp_d.zero = 2'b00; // R3
      rsp_d.code = res_code_q[req_chan];
      if (is_esr_code(res_code_q[req_chan]) && !esr_results_available)
        rsp_d.code = CODE_RESET; // R19
      rsp_d.result = result_q[req_chan]; // R8
    end
    ready_low_d = pair_ready(fresh_d, 1'b0); // R6
    ready_high_d = pair_ready(fresh_d, 1'b1); // R6
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      active_chan_q <= CHAN_A;
      active_code_q <= CODE_RESET;
      conv_start_q <= 1'b0;
      conv_sel_q <= '{node: NODE_UNUSED, index: 6'h00};
    end else if (clk_en) begin
      state_q <= state_d;
      active_chan_q <= active_chan_d;
      active_code_q <= active_code_d;
      conv_start_q <= conv_start_d;
      conv_sel_q <= conv_sel_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fresh_q <= 4'h0; // R22
      pend_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        pend_code_q[i] <= CODE_RESET;
        result_q[i] <= RESULT_RESET; // R22
        res_code_q[i] <= CODE_RESET;
      end
    end else if (clk_en) begin
      fresh_q <= fresh_d;
      pend_q <= pend_d;
      pend_code_q <= pend_code_d;
      result_q <= result_d;
      res_code_q <= res_code_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      ready_low_q <= 1'b0;
      ready_high_q <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      ready_low_q <= ready_low_d;
      ready_high_q <= ready_high_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign ready_pair_low = ready_low_q;
  assign ready_pair_high = ready_high_q;
  assign conv_start = conv_start_q;
  assign conv_sel = conv_sel_q;
  assign conv_busy = (state_q == ST_CONVERT);
  assign pending_mask = pend_q;

endmodule // diag_adc_request_queue
`default_nettype wire

// File: verif/adc_stand_in.sv
/*
  Converter stand-in: one done pulse per start pulse, numbered results.
  Assumes conv_start is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_stand_in (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic conv_start,
  output logic conv_done,
  output logic [9:0] conv_result,
  output logic [9:0] conv_result_aux
);
  logic [9:0] count_q;
  int wait_q;
  always_ff @(posedge sys_clk) begin
    conv_done <= 1'h0;
    if (!rst_n) begin
      count_q <= 10'h000;
      wait_q <= 0;
      conv_result <= 10'h000;
      conv_result_aux <= 10'h000;
    end else if (conv_start) begin
      wait_q <= slow ? 12 : 2;
    end else if (wait_q == 1) begin
      conv_done <= 1'h1;
      conv_result <= 10'h100 + count_q;
      conv_result_aux <= 10'h200 + count_q;
      count_q <= count_q + 10'h001;
      wait_q <= 0;
    end else begin
      // result lines toggle outside the start and done cycles
      conv_result <= ~conv_result;
      conv_result_aux <= ~conv_result_aux;
      if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule // adc_stand_in
`default_nettype wire

// File: verif/diag_adc_request_queue_checker.sv
/*
  Port assertions for the request queue.
  Bound to every instance of diag_adc_request_queue.
*/
`timescale 1ns/1ns
`default_nettype none
module diag_adc_request_queue_checker
  import diag_adc_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire spi_cmd_type cmd,
  input wire logic rsp_valid,
  input wire diag_frame_type rsp,
  input wire logic ready_pair_low,
  input wire logic ready_pair_high,
  input wire logic conv_start,
  input wire node_sel_type conv_sel,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic [3:0] pending_mask
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic hit;
  assign hit = cmd_valid && clk_en && cmd.addr >= ADDR_CHANNEL_A && cmd.addr <= ADDR_CHANNEL_D;
  a_reply_after_hit: assert property (hit |=> rsp_valid)
    else $error("no reply to command");
  a_miss_no_reply: assert property (!hit && clk_en |=> !rsp_valid)
    else $error("reply without command");
  a_reply_zero_bits: assert property (rsp_valid |-> rsp.zero == 2'h0)
    else $error("reply bits 18:17 set");
  a_done_sets_ready: assert property (conv_done && conv_busy |-> ##[1:2] (ready_pair_low || ready_pair_high))
    else $error("ready pair low after done");
  a_start_single_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_start_marks_busy: assert property (conv_start |-> conv_busy)
    else $error("start without busy");
  a_done_frees_converter: assert property (conv_done && conv_busy && clk_en |=> !conv_busy)
    else $error("busy after done");
  a_start_needs_request: assert property (conv_start |-> $past(pending_mask) != 4'h0)
    else $error("start with empty queue");
  c_read_fresh: cover property (hit ##1 rsp_valid && rsp.flag);
  c_queue_three: cover property (pending_mask == 4'hB);
  c_pin_start: cover property (conv_start && conv_sel.node == NODE_PIN);
endmodule // diag_adc_request_queue_checker
bind diag_adc_request_queue diag_adc_request_queue_checker #(.CHANNELS(CHANNELS), .DEPTH(DEPTH)) i_checker (
  .sys_clk, .rst_n, .clk_en, .cmd_valid, .cmd, .rsp_valid, .rsp, .ready_pair_low, .ready_pair_high,
  .conv_start, .conv_sel, .conv_done, .conv_busy, .pending_mask);
`default_nettype wire

// File: verif/diag_adc_request_queue_tb.sv
/*
  Self-checking bench for the request queue.
  Drives decoded frames; adc_stand_in plays the converter.
*/
`timescale 1ns/1ns
`default_nettype none
module diag_adc_request_queue_tb
  import diag_adc_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cmd_valid = 1'h0;
  logic ce = 1'h1;
  logic series_resistance_check = 1'h1;
  logic slow = 1'h0;
  spi_cmd_type cmd = '0;
  logic rsp_valid, ready_pair_low, ready_pair_high, conv_start, conv_done, conv_busy;
  diag_frame_type rsp;
  node_sel_type conv_sel;
  logic [9:0] conv_result, conv_result_aux;
  logic [3:0] pending_mask;
  logic [20:0] got;
  int mismatches = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  diag_adc_request_queue i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .cmd_valid(cmd_valid),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .ready_pair_low(ready_pair_low),
    .ready_pair_high(ready_pair_high), .esr_results_available(series_resistance_check), .conv_start(conv_start),
    .conv_sel(conv_sel), .conv_done(conv_done), .conv_result(conv_result),
    .conv_result_aux(conv_result_aux), .conv_busy(conv_busy), .pending_mask(pending_mask));
  adc_stand_in i_adc (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result), .conv_result_aux(conv_result_aux));
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [20:0] frm(logic f, logic [6:0] c, logic [9:0] r);
    return {1'h1, f, 2'h0, c, r};
  endfunction
  // leaves cmd_valid high so back-to-back calls issue one command per cycle
  task automatic send(input logic [7:0] addr, input logic [6:0] code);
    cmd_valid = 1'h1;
    cmd = {addr, 9'h1FF, code};
    @(negedge sys_clk);
    got = {rsp_valid, rsp};
  endtask
  task automatic idle;
    cmd_valid = 1'h0;
    @(negedge sys_clk);
  endtask
  task automatic settle;
    int t;
    t = 0;
    while ((conv_busy || pending_mask !== 4'h0) && t < 300) begin
      @(negedge sys_clk);
      t++;
    end
    chk({20'h0, t == 300}, 21'h0);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      send(ADDR_CHANNEL_A + 8'(i), 7'h00);
      chk(got, frm(1'h0, 7'h00, 10'h000));
    end
    send(8'h39, 7'h01);
    chk({20'h0, got[20]}, 21'h0);
    idle;
    settle;
    chk({19'h0, ready_pair_high, ready_pair_low}, 21'h3);
    $display("t_reset done");
  endtask
  task automatic t_read;
    slow = 1'h1;
    send(ADDR_CHANNEL_A, 7'h21);
    chk(got, frm(1'h1, 7'h00, 10'h100));
    send(ADDR_CHANNEL_B, 7'h0B);
    chk(got, frm(1'h1, 7'h00, 10'h101));
    chk({19'h0, conv_start, conv_busy}, 21'h3);
    idle;
    chk({19'h0, conv_start, conv_busy}, 21'h1);
    chk({20'h0, ready_pair_low}, 21'h0);
    chk({11'h0, conv_sel}, {11'h0, NODE_PIN, 6'h01});
    settle;
    send(ADDR_CHANNEL_A, 7'h21);
    chk(got, frm(1'h1, 7'h21, 10'h104));
    idle;
    send(ADDR_CHANNEL_A, 7'h21);
    chk(got, frm(1'h0, 7'h21, 10'h104));
    idle;
    settle;
    $display("t_read done");
  endtask
  task automatic t_order;
    send(ADDR_CHANNEL_C, 7'h07);
    chk(got, frm(1'h1, 7'h00, 10'h102));
    send(ADDR_CHANNEL_D, 7'h08);
    send(ADDR_CHANNEL_A, 7'h0A);
    send(ADDR_CHANNEL_B, 7'h14);
    send(ADDR_CHANNEL_B, 7'h06);
    chk(got, frm(1'h0, 7'h0B, 10'h105));
    idle;
    chk({17'h0, pending_mask}, 21'hB);
    settle;
    send(ADDR_CHANNEL_A, 7'h00);
    chk(got, frm(1'h1, 7'h0A, 10'h10A));
    send(ADDR_CHANNEL_B, 7'h00);
    chk(got, frm(1'h1, 7'h06, 10'h10B));
    send(ADDR_CHANNEL_C, 7'h00);
    chk(got, frm(1'h1, 7'h07, 10'h108));
    send(ADDR_CHANNEL_D, 7'h00);
    chk(got, frm(1'h1, 7'h08, 10'h109));
    idle;
    settle;
    $display("t_order done");
  endtask
  task automatic t_map;
    logic [6:0] codes [15] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0A, 7'h0B, 7'h13, 7'h15,
      7'h16, 7'h17, 7'h3D};
    node_class_type nodes [15] = '{NODE_GROUND, NODE_FULLSCALE, NODE_DCS_VOLT, NODE_DCS_CURR, NODE_DCS_RES,
      NODE_SQUIB, NODE_BANDGAP, NODE_BG_MON, NODE_TEMP, NODE_DCS_CHANNEL, NODE_DCS_CHANNEL, NODE_ESR, NODE_ESR,
      NODE_UNUSED, NODE_PIN};
    logic [5:0] idx [15] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h08, 6'h01,
      6'h02, 6'h00, 6'h1D};
    slow = 1'h0;
    for (int i = 0; i < 15; i++) begin
      send(ADDR_CHANNEL_C, codes[i]);
      idle;
      settle;
      chk({11'h0, conv_sel}, {11'h0, nodes[i], idx[i]});
    end
    $display("t_map done");
  endtask
  task automatic t_special;
    send(ADDR_CHANNEL_A, 7'h05);
    idle;
    settle;
    send(ADDR_CHANNEL_A, 7'h00);
    chk(got, frm(1'h1, 7'h05, 10'h11F));
    send(ADDR_CHANNEL_B, 7'h00);
    chk(got, frm(1'h1, 7'h05, 10'h21F));
    send(ADDR_CHANNEL_D, 7'h15);
    idle;
    settle;
    send(ADDR_CHANNEL_D, 7'h15);
    chk(got, frm(1'h1, 7'h15, 10'h122));
    idle;
    series_resistance_check = 1'h0;
    settle;
    send(ADDR_CHANNEL_D, 7'h00);
    chk(got, frm(1'h1, 7'h00, 10'h123));
    idle;
    settle;
    $display("t_special done");
  endtask
  // frozen cycles must neither answer, queue nor clear a flag
  task automatic t_freeze;
    ce = 1'h0;
    send(ADDR_CHANNEL_A, 7'h01);
    chk({16'h0, got[20], pending_mask}, 21'h0);
    idle;
    ce = 1'h1;
    send(ADDR_CHANNEL_A, 7'h00);
    chk(got, frm(1'h1, 7'h00, 10'h120));
    idle;
    settle;
    $display("t_freeze done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'h1;
    t_reset;
    t_read;
    t_order;
    t_map;
    t_special;
    t_freeze;
    tally_and_finish;
  end
endmodule // diag_adc_request_queue_tb
`default_nettype wire
